// file: tcc_map.vh
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// Register offsets on the plain register port (word addresses).
`define TCC_ADDR_W        5
`define TCC_ADDR_CTRL     5'h00
`define TCC_ADDR_EVCTRL   5'h01
`define TCC_ADDR_FLAGS    5'h02
`define TCC_ADDR_BVSTAT   5'h03
`define TCC_ADDR_CNT      5'h04
`define TCC_ADDR_PER      5'h05
`define TCC_ADDR_PERIOD_SHADOW   5'h06
`define TCC_ADDR_CC0      5'h08
`define TCC_ADDR_CCBUF0   5'h0C

// Control register fields.
`define TCC_CTRL_CLOCK_SOURCE_SELECT_LSB 0
`define TCC_CTRL_CLOCK_SOURCE_SELECT_MSB 3
`define TCC_CTRL_DIR        4
`define TCC_CTRL_TOPCCA     5
`define TCC_CTRL_UPDTOP     6
`define TCC_CTRL_CAPMODE    7
`define TCC_CTRL_CCEN_LSB   8
`define TCC_CTRL_CCEN_MSB   11
`define TCC_CTRL_SPLIT      12
`define TCC_CTRL_RESET      16'h0000

// Event control register fields.
`define TCC_EV_SEL_LSB    0
`define TCC_EV_SEL_MSB    2
`define TCC_EV_ACT_LSB    4
`define TCC_EV_ACT_MSB    6
`define TCC_EVCTRL_RESET  16'h0000

// Event actions.
`define TCC_ACT_OFF       3'h0
`define TCC_ACT_CAPT      3'h1
`define TCC_ACT_FRQ       3'h2
`define TCC_ACT_UPDN      3'h3
`define TCC_ACT_QUADRATURE_DECODER      3'h4

// Clock source select codes.
`define TCC_CLK_OFF       4'h0
`define TCC_CLK_EV_BASE   4'h8

// Status flag positions.
`define TCC_FLAG_OVF      0
`define TCC_FLAG_ERR      1
`define TCC_FLAG_BOTTOM   2
`define TCC_FLAG_MAX      3
`define TCC_FLAG_CC_LSB   4

// Period reset value: all ones.
`define TCC_PER_RESET     16'hFFFF

`endif

// file: tcc_core.v
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
`include "tcc_map.vh"

module tcc_core #(
   parameter VARIANT = 0,
   parameter NEV     = 8
)(
   // Clock and reset
   input  wire        ref_clk_i,
   input  wire        resetn_i,
   // Register port
   input  wire [4:0]  addr_i,
   input  wire [15:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [15:0] rdata_o,
   // Shared prescaler taps and event channels
   input  wire [6:0]  pres_i,
   input  wire [7:0]  ev_i,
   // Requests and events
   output reg  [7:0]  flags_o,
   output reg  [3:0]  dma_req_o,
   output reg         ovf_evt_o,
   output reg  [3:0]  cc_evt_o
);

   localparam CH = (VARIANT == 0) ? 4 : 2;

   reg  [15:0] ctrl;
   reg  [15:0] evctrl;
   reg  [7:0]  flags;
   reg  [15:0] cnt;
   reg  [15:0] per;
   reg  [15:0] period_shadow;
   reg         per_bv;
   reg  [15:0] cc     [0:3];
   reg  [15:0] ccbuf  [0:3];
   reg  [3:0]  bv;

   wire [3:0]  clock_source_select  = ctrl[`TCC_CTRL_CLOCK_SOURCE_SELECT_MSB:`TCC_CTRL_CLOCK_SOURCE_SELECT_LSB];
   wire        capmode = ctrl[`TCC_CTRL_CAPMODE];
   wire [3:0]  ccen    = ctrl[`TCC_CTRL_CCEN_MSB:`TCC_CTRL_CCEN_LSB];
   wire        split   = (VARIANT == 0) && ctrl[`TCC_CTRL_SPLIT];
   wire [2:0]  event_input_select   = evctrl[`TCC_EV_SEL_MSB:`TCC_EV_SEL_LSB];
   wire [2:0]  event_action_select   = evctrl[`TCC_EV_ACT_MSB:`TCC_EV_ACT_LSB];

   reg         tick;
   reg  [15:0] top;
   reg         down;
   reg         at_top;
   reg         at_bot;
   reg         wrap;
   reg         update;
   reg         restart;
   reg  [15:0] next_cnt;
   reg  [7:0]  next_flags;
   reg  [7:0]  flag_set;
   reg  [7:0]  flag_clr;
   reg  [3:0]  cap_ev;
   reg  [3:0]  cap_do;
   reg  [3:0]  cap_ovf;
   reg  [3:0]  xfer;
   reg  [3:0]  match;
   reg  [3:0]  rd_cc;
   reg  [2:0]  idx;
   reg  [15:0] next_rdata;
   reg  [7:0]  lo;
   reg  [7:0]  hi;
   integer     k;
   integer     kc;
   integer     kr;

   wire cnt_wr = wr_i && (addr_i == `TCC_ADDR_CNT);

   // Counter clock, direction and TOP/BOTTOM detection.
   always @*
   begin
      if (clock_source_select == `TCC_CLK_OFF)
         tick = 1'b0;
      else if (clock_source_select < `TCC_CLK_EV_BASE)
         tick = pres_i[clock_source_select[2:0] - 3'h1];
      else
         tick = ev_i[clock_source_select[2:0]];
      top = ctrl[`TCC_CTRL_TOPCCA] ? cc[0] : per;
      if (event_action_select == `TCC_ACT_UPDN)
         down = ev_i[event_input_select];
      else if (event_action_select == `TCC_ACT_QUADRATURE_DECODER)
         down = ev_i[event_input_select + 3'h1];
      else
         down = ctrl[`TCC_CTRL_DIR];
      at_top  = (cnt == top);
      at_bot  = (cnt == 16'h0000);
      wrap    = tick && (down ? at_bot : at_top);
      update  = tick && (ctrl[`TCC_CTRL_UPDTOP] ? at_top : at_bot);
      restart = capmode && (event_action_select == `TCC_ACT_FRQ) && ccen[0] && ev_i[event_input_select];
      lo = cnt[7:0];
      hi = cnt[15:8];
      if (split)
      begin
         lo = (cnt[7:0] == 8'h00) ? per[7:0] : cnt[7:0] - 8'h01;
         hi = (cnt[15:8] == 8'h00) ? per[15:8] : cnt[15:8] - 8'h01;
      end
      next_cnt = cnt;
      if (cnt_wr)
         next_cnt = wdata_i;
      else if (restart)
         next_cnt = 16'h0000;
      else if (tick && split)
         next_cnt = {hi, lo};
      else if (tick)
      begin
         if (down)
            next_cnt = at_bot ? per : cnt - 16'h0001;
         else
            next_cnt = at_top ? 16'h0000 : cnt + 16'h0001;
      end
   end

   // Channel capture, queue transfer and compare match.
   always @*
   begin
      cap_ev  = 4'h0;
      cap_do  = 4'h0;
      cap_ovf = 4'h0;
      xfer    = 4'h0;
      match   = 4'h0;
      rd_cc   = 4'h0;
      idx     = 3'h0;
      for (kc = 0; kc < CH; kc = kc + 1)
      begin
         idx      = event_input_select + kc[2:0];
         cap_ev[kc] = ev_i[idx];
         rd_cc[kc] = rd_i && (addr_i == `TCC_ADDR_CC0 + kc[4:0]);
         cap_do[kc] = capmode && ccen[kc] && cap_ev[kc] &&
                      ((event_action_select == `TCC_ACT_CAPT) || (event_action_select == `TCC_ACT_FRQ));
         cap_ovf[kc] = cap_do[kc] && bv[kc] && flags[`TCC_FLAG_CC_LSB + kc] && !rd_cc[kc];
         xfer[kc] = capmode && bv[kc] && (!flags[`TCC_FLAG_CC_LSB + kc] || rd_cc[kc]);
         if (split)
            match[kc] = !capmode && tick &&
                        ((cnt[7:0] == cc[kc][7:0]) || (cnt[15:8] == cc[kc][15:8]));
         else
            match[kc] = !capmode && tick && (cnt == cc[kc]);
      end
   end

   // Flag set and clear; a set in the clearing cycle wins.
   always @*
   begin
      flag_set = 8'h00;
      flag_set[`TCC_FLAG_OVF]    = wrap;
      flag_set[`TCC_FLAG_ERR]    = |cap_ovf;
      flag_set[`TCC_FLAG_BOTTOM] = (next_cnt == 16'h0000) && (cnt != 16'h0000);
      flag_set[`TCC_FLAG_MAX]    = (next_cnt == 16'hFFFF) && (cnt != 16'hFFFF);
      flag_set[7:4] = match | xfer;
      flag_clr = 8'h00;
      if (wr_i && (addr_i == `TCC_ADDR_FLAGS))
         flag_clr = wdata_i[7:0];
      if (capmode)
         flag_clr[7:4] = flag_clr[7:4] | rd_cc;
      next_flags = (flags & ~flag_clr) | flag_set;
   end

   // Register readback.
   always @*
   begin
      next_rdata = 16'h0000;
      case (addr_i)
         `TCC_ADDR_CTRL   : next_rdata = ctrl;
         `TCC_ADDR_EVCTRL : next_rdata = evctrl;
         `TCC_ADDR_FLAGS  : next_rdata = {8'h00, flags};
         `TCC_ADDR_BVSTAT : next_rdata = {11'h000, bv, per_bv};
         `TCC_ADDR_CNT    : next_rdata = cnt;
         `TCC_ADDR_PER    : next_rdata = per;
         `TCC_ADDR_PERIOD_SHADOW : next_rdata = period_shadow;
         default          : next_rdata = 16'h0000;
      endcase
      for (kr = 0; kr < CH; kr = kr + 1)
      begin
         if (addr_i == `TCC_ADDR_CC0 + kr[4:0])
            next_rdata = cc[kr];
         if (addr_i == `TCC_ADDR_CCBUF0 + kr[4:0])
            next_rdata = ccbuf[kr];
      end
   end

   always @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         ctrl      <= `TCC_CTRL_RESET;
         evctrl    <= `TCC_EVCTRL_RESET;
         flags     <= 8'h00;
         cnt       <= 16'h0000;
         per       <= `TCC_PER_RESET;
         period_shadow    <= 16'h0000;
         per_bv    <= 1'b0;
         bv        <= 4'h0;
         rdata_o   <= 16'h0000;
         flags_o   <= 8'h00;
         dma_req_o <= 4'h0;
         ovf_evt_o <= 1'b0;
         cc_evt_o  <= 4'h0;
         for (k = 0; k < 4; k = k + 1)
         begin
            cc[k]    <= 16'h0000;
            ccbuf[k] <= 16'h0000;
         end
      end
      else
      begin
         if (wr_i && (addr_i == `TCC_ADDR_CTRL))
            ctrl <= wdata_i;
         if (wr_i && (addr_i == `TCC_ADDR_EVCTRL))
            evctrl <= wdata_i;
         cnt   <= next_cnt;
         flags <= next_flags;
         // Period double buffering.
         if (wr_i && (addr_i == `TCC_ADDR_PER))
            per <= wdata_i;
         else if (update && per_bv)
            per <= period_shadow;
         if (wr_i && (addr_i == `TCC_ADDR_PERIOD_SHADOW))
         begin
            period_shadow <= wdata_i;
            per_bv <= 1'b1;
         end
         else if (update)
            per_bv <= 1'b0;
         for (k = 0; k < CH; k = k + 1)
         begin
            if (wr_i && (addr_i == `TCC_ADDR_CC0 + k[4:0]))
               cc[k] <= wdata_i;
            else if (xfer[k])
               cc[k] <= ccbuf[k];
            else if (!capmode && update && bv[k])
               cc[k] <= ccbuf[k];
            if (wr_i && (addr_i == `TCC_ADDR_CCBUF0 + k[4:0]))
               ccbuf[k] <= wdata_i;
            else if (cap_do[k] && !cap_ovf[k])
               ccbuf[k] <= cnt;
            if ((wr_i && (addr_i == `TCC_ADDR_CCBUF0 + k[4:0])) || (cap_do[k] && !cap_ovf[k]))
               bv[k] <= 1'b1;
            else if (xfer[k] || (!capmode && update))
               bv[k] <= 1'b0;
         end
         rdata_o   <= rd_i ? next_rdata : 16'h0000;
         flags_o   <= next_flags;
         dma_req_o <= next_flags[7:4];
         ovf_evt_o <= wrap;
         cc_evt_o  <= match | xfer;
      end
   end

endmodule

// file: tcc_prescaler.sv
`timescale 1ns/1ns
module tcc_prescaler (
   // Clock and reset
   input  wire       ref_clk_i,
   input  wire       resetn_i,
   // Shared tap strobes
   output wire [6:0] pres_o
);
   reg [9:0] div;
   always @(posedge ref_clk_i)
      if (!resetn_i)
         div <= 10'h000;
      else
         div <= div + 10'h001;
   // Each tap strobes for one cycle per period of its division, from one to one over 1024.
   assign pres_o = {div == 10'h3FF, div[7:0] == 8'hFF, div[5:0] == 6'h3F,
                    div[2:0] == 3'h7, div[1:0] == 2'h3, div[0], 1'b1};
endmodule

// file: tcc_core_properties.sv
`timescale 1ns/1ns
`include "tcc_map.vh"
module tcc_core_properties (
   input wire        ref_clk_i,
   input wire        resetn_i,
   input wire [4:0]  addr_i,
   input wire [15:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [15:0] rdata_o,
   input wire [7:0]  flags_o,
   input wire [3:0]  dma_req_o,
   input wire        ovf_evt_o,
   input wire [3:0]  cc_evt_o
);
   reg [3:0] sel;
   reg       dn;
   reg       idle;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // Shadow of the clock select and direction, taken from control writes.
   always @(posedge ref_clk_i)
      if (!resetn_i)
      begin
         sel  <= 4'h0;
         dn   <= 1'b0;
         idle <= 1'b0;
      end
      else
      begin
         idle <= sel == 4'h0;
         if (wr_i && addr_i == `TCC_ADDR_CTRL)
         begin
            sel <= wdata_i[3:0];
            dn  <= wdata_i[4];
         end
      end
   read_rest_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("stray read data");
   unmapped_read_a: assert property (rd_i && addr_i == 5'h07 |=> rdata_o == 16'h0000) else $error("hole read");
   dma_mirror_a: assert property (dma_req_o == flags_o[7:4]) else $error("dma request differs from flag");
   wrap_pulse_a: assert property (ovf_evt_o |=> !ovf_evt_o) else $error("wrap event too long");
   wrap_flag_a: assert property (ovf_evt_o |-> flags_o[`TCC_FLAG_OVF]) else $error("wrap flag missing");
   bottom_flag_a: assert property (ovf_evt_o && !dn && $stable(dn) |-> flags_o[`TCC_FLAG_BOTTOM])
      else $error("bottom flag missing");
   stop_quiet_a: assert property (sel == 4'h0 && idle |=> !ovf_evt_o) else $error("stopped counter wrapped");
   cc_flag_a: assert property ((cc_evt_o & ~flags_o[7:4]) == 4'h0) else $error("channel event without flag");
   cover property (ovf_evt_o);
   cover property (cc_evt_o[0]);
   cover property (flags_o[`TCC_FLAG_ERR]);
endmodule
bind tcc_core tcc_core_properties props_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flags_o(flags_o),
   .dma_req_o(dma_req_o), .ovf_evt_o(ovf_evt_o), .cc_evt_o(cc_evt_o));

// file: test_tcc_core.sv
`timescale 1ns/1ns
`include "tcc_map.vh"
module test_tcc_core;
   reg         ref_clk_i  = 1'b0;
   reg         resetn_i   = 1'b0;
   reg  [4:0]  addr_i     = 5'h00;
   reg  [15:0] wdata_i    = 16'h0000;
   reg         wr_i       = 1'b0;
   reg         rd_i       = 1'b0;
   reg  [7:0]  ev_i       = 8'h00;
   reg  [15:0] rv;
   reg  [15:0] cap [0:2];
   reg         pbv;
   reg         upd;
   wire [15:0] rdata_o;
   wire [6:0]  pres_i;
   wire [7:0]  flags_o;
   wire [3:0]  dma_req_o;
   wire        ovf_evt_o;
   wire [3:0]  cc_evt_o;
   integer     num_errors = 0;
   integer     cmp_count  = 0;
   integer     cnt, per, pbuf, i;
   always #50 ref_clk_i = ~ref_clk_i;
   tcc_prescaler pre_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pres_o(pres_i));
   tcc_core dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pres_i(pres_i), .ev_i(ev_i), .flags_o(flags_o),
      .dma_req_o(dma_req_o), .ovf_evt_o(ovf_evt_o), .cc_evt_o(cc_evt_o));
   task chk(input [15:0] got, input [15:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task wr(input [4:0] a, input [15:0] d);
   begin
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   end
   endtask
   task rd(input [4:0] a);
   begin
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
      @(negedge ref_clk_i);
      rv = rdata_o;
   end
   endtask
   task rdc(input [4:0] a, input [15:0] e);
   begin
      rd(a);
      chk(rv, e);
   end
   endtask
   // Pulses the event clock channel and steps the reference counter with it.
   task tick(input integer dn, input integer m);
   begin
      repeat (m)
      begin
         @(posedge ref_clk_i);
         ev_i[0] <= 1'b1;
         @(posedge ref_clk_i);
         ev_i[0] <= 1'b0;
         // UPDATE is the tick taken while the count stands at BOTTOM; the old period still applies.
         upd = (cnt == 0) && pbv;
         if (dn)
            cnt = (cnt == 0) ? per : cnt - 1;
         else
            cnt = (cnt == per) ? 0 : cnt + 1;
         if (upd)
         begin
            per = pbuf;
            pbv = 0;
         end
      end
   end
   endtask
   task results;
   begin
      $display("Errors: %0d, comparisons: %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      #500000;
      num_errors = num_errors + 1;
      results;
   end
   initial
   begin
      i = $urandom(32'hCA5C);
      repeat (12) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rdc(`TCC_ADDR_CTRL, `TCC_CTRL_RESET);
      rdc(`TCC_ADDR_PER, `TCC_PER_RESET);
      repeat (20) @(posedge ref_clk_i);
      rdc(`TCC_ADDR_CNT, 16'h0000);
      rdc(5'h07, 16'h0000);
      per = 5;
      pbv = 0;
      cnt = $urandom_range(5, 0);
      wr(`TCC_ADDR_PER, per);
      wr(`TCC_ADDR_CNT, cnt);
      rdc(`TCC_ADDR_CNT, cnt);
      wr(`TCC_ADDR_CTRL, 16'h0008);
      tick(0, $urandom_range(12, 1));
      rdc(`TCC_ADDR_CNT, cnt);
      wr(`TCC_ADDR_CTRL, 16'h0018);
      tick(1, $urandom_range(12, 1));
      rdc(`TCC_ADDR_CNT, cnt);
      wr(`TCC_ADDR_CTRL, 16'h0008);
      pbuf = 9;
      pbv = 1;
      wr(`TCC_ADDR_PERIOD_SHADOW, pbuf);
      rdc(`TCC_ADDR_BVSTAT, 16'h0001);
      rdc(`TCC_ADDR_PER, per);
      tick(0, 8);
      rdc(`TCC_ADDR_PER, per);
      rdc(`TCC_ADDR_BVSTAT, 16'h0000);
      rdc(`TCC_ADDR_CNT, cnt);
      wr(`TCC_ADDR_CTRL, 16'h0001);
      repeat (40) @(posedge ref_clk_i);
      wr(`TCC_ADDR_CTRL, 16'h0180);
      rd(`TCC_ADDR_CNT);
      chk({15'h0000, rv <= per}, 16'h0001);
      wr(`TCC_ADDR_FLAGS, 16'h00FF);
      wr(`TCC_ADDR_EVCTRL, 16'h0011);
      for (i = 0; i < 3; i = i + 1)
      begin
         cap[i] = $urandom_range(16'hFFFE, 16'h0010);
         wr(`TCC_ADDR_CNT, cap[i]);
         @(posedge ref_clk_i);
         ev_i[1] <= 1'b1;
         @(posedge ref_clk_i);
         ev_i[1] <= 1'b0;
      end
      repeat (2) @(negedge ref_clk_i);
      chk({8'h00, flags_o}, 16'h0012);
      chk({12'h000, dma_req_o}, 16'h0001);
      rdc(`TCC_ADDR_BVSTAT, 16'h0002);
      rdc(`TCC_ADDR_CC0, cap[0]);
      rdc(`TCC_ADDR_CC0, cap[1]);
      rdc(`TCC_ADDR_BVSTAT, 16'h0000);
      wr(`TCC_ADDR_CTRL, 16'h0208);
      cnt = 0;
      wr(`TCC_ADDR_CNT, 16'h0000);
      wr(`TCC_ADDR_FLAGS, 16'h00FF);
      wr(`TCC_ADDR_CC0 + 5'h03, 16'h5A5A);
      rdc(`TCC_ADDR_CC0 + 5'h03, 16'h5A5A);
      wr(`TCC_ADDR_CC0 + 5'h01, 16'h0003);
      wr(`TCC_ADDR_CCBUF0 + 5'h01, 16'h0002);
      rdc(`TCC_ADDR_CCBUF0 + 5'h01, 16'h0002);
      rdc(`TCC_ADDR_BVSTAT, 16'h0004);
      tick(0, 10);
      rdc(`TCC_ADDR_CC0 + 5'h01, 16'h0002);
      chk({8'h00, flags_o}, 16'h0065);
      rdc(`TCC_ADDR_BVSTAT, 16'h0000);
      results;
   end
endmodule
